// [smbtc_bus_peer.sv]
// Purpose: other devices sharing the open-drain bus lines
// Assumes: pull-ups on both lines
// Notes: link clock runs only inside frames, 160 ns period
`timescale 1ns/1ps
module smbtc_bus_peer (
    // Device drive
    input wire logic sclOe,
    input wire logic sdaOe,
    // Resolved lines
    output logic sclLine,
    output logic sdaLine
);
    logic sclLow = 1'b0;
    logic sdaLow = 1'b0;
    // Released lines float high through the pull-ups
    assign sclLine = !(sclOe || sclLow);
    assign sdaLine = !(sdaOe || sdaLow);
    task automatic holdScl(input logic v);
        sclLow = v;
    endtask
    task automatic start();
        #7 sdaLow = 1'b1;
        #80;
    endtask
    task automatic pulses(input int n);
        repeat (n)
        begin
            sclLow = 1'b1;
            #80 sclLow = 1'b0;
            #80;
        end
    endtask
    task automatic stop();
        sclLow = 1'b1;
        sdaLow = 1'b1;
        #80 sclLow = 1'b0;
        #80 sdaLow = 1'b0;
        #80;
    endtask
endmodule

// [smbtc_free_timer.sv]
// Purpose: bus-free timer, counts up while both lines are high
// Assumes: synchronised line levels
// Notes: overflow is a one-cycle pulse; reloads from the rate value otherwise
`timescale 1ns/1ps
module smbtc_free_timer
    import smbtc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Control
    input wire logic enable,
    input wire logic [7:0] reloadValue,
    input wire logic sclHigh,
    input wire logic sdaHigh,
    // Result
    output logic overflow
);
    logic [7:0] count_ff;
    logic overflow_ff;

    always_ff @(posedge sys_clk)
    begin
        if (srst || !enable || !sclHigh || !sdaHigh)
        begin
            count_ff <= reloadValue;
        end
        else if (count_ff == TIMER_TOP)
        begin
            // Wraps to the reload value so a long idle bus keeps firing
            count_ff <= reloadValue; // RQ4
        end
        else
        begin
            count_ff <= count_ff + 8'h01; // RQ3
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            overflow_ff <= 1'b0;
        end
        else
        begin
            overflow_ff <= enable && sclHigh && sdaHigh && (count_ff == TIMER_TOP); // RQ1
        end
    end

    assign overflow = overflow_ff;
endmodule

// [smbtc_pkg.sv]
// Purpose: shared constants and types for the bus timeout and control block
// Assumes: 50 MHz system clock
// Notes: special-function register addresses are byte addresses on the SFR port
package smbtc_pkg;
    localparam int unsigned SYS_CLK_HZ = 50000000;
    localparam int unsigned SYS_CLK_PERIOD_NS = 1000000000 / SYS_CLK_HZ;
    localparam logic [7:0] CTRL_ADDR = 8'hC0;
    localparam logic [7:0] RATE_ADDR = 8'hCF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam int BIT_BUSY = 7;
    localparam int BIT_ENABLE = 6;
    localparam int BIT_START = 5;
    localparam int BIT_STOP = 4;
    localparam int BIT_IRQ = 3;
    localparam int BIT_ACK = 2;
    localparam int BIT_FREE_TE = 1;
    localparam int BIT_LOW_TE = 0;
    // Bus-free limit and bus condition hold time
    localparam int unsigned BUS_FREE_US = 50;
    localparam int unsigned COND_HOLD_NS = 4000;
    localparam int unsigned COND_HOLD_CYC =
        (COND_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } smbtc_sfr_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } smbtc_pin_drv_t;
endpackage

// [smbtc_top.sv]
// Purpose: timeout detection and control register of the two-wire bus interface
// Assumes: open-drain lines, pins sampled through two flip-flops
// Notes: byte shifting engine lives elsewhere; this block frames START and STOP
// Function
// RQ1: Bus counts as free once clock and data stay high past 50 us.
// RQ2: Writing 1 to the free timer enable bit starts the bus-free timer.
// RQ3: Enabled bus-free timer counts upward while the clock line is high; here it also reloads whenever the data line is low.
// RQ4: Timer overflow marks bus free; a pending START goes out only afterwards. Here a non-busy bus also starts with free timer enable clear or on a STOP.
// RQ5: Software loads the rate register so the free period stays below 50 us.
// RQ6: Low timeout enable couples the general timer to clock-low detection.
// RQ7: Coupled timer reloads while clock is high and counts while it is low.
// RQ8: Software sets the general timer to 25 ms and resets bus on overflow.
// RQ9: Bit 7 is read-only busy: 0 when free, 1 during a transfer.
// RQ10: Interface enable bit gates the whole serial interface; the low timeout coupling here runs without it.
// RQ11: START when free, else after STOP; repeated START if set mid-transfer.
`timescale 1ns/1ps
module smbtc_top
    import smbtc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire smbtc_sfr_req_t sfrReq,
    output logic [7:0] sfrRdData,
    // Bus lines
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // General timer coupling
    input wire logic lowTimerEnabled,
    output logic lowTimerReload,
    output logic lowTimerCount,
    // Status
    output logic busFreeTimeout
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_FREE,
        ST_START_HOLD,
        ST_MASTER,
        ST_RS_RELEASE,
        ST_STOP_SETUP,
        ST_STOP_HOLD
    } smbtc_state_t;

    smbtc_state_t state_ff;
    logic [1:0] sclSync_ff;
    logic [1:0] sdaSync_ff;
    logic sclPrev_ff;
    logic sdaPrev_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] rate_ff;
    logic busy_ff;
    logic [15:0] holdCnt_ff;
    logic [7:0] rdData_ff;
    logic sclOe_ff;
    logic sdaOe_ff;
    logic reload_ff;
    logic count_ff;
    logic freeTo_ff;
    logic freeOvf;
    logic sclNow;
    logic sdaNow;
    logic startSeen;
    logic stopSeen;
    logic ctrlWr;
    logic holdDone;
    logic genEvent;

    function automatic logic sfrHit(input smbtc_sfr_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    // Only the second stage is read by logic
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sclSync_ff <= 2'h3;
            sdaSync_ff <= 2'h3;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end
        else
        begin
            sclSync_ff <= {sclSync_ff[0], sclIn};
            sdaSync_ff <= {sdaSync_ff[0], sdaIn};
            sclPrev_ff <= sclSync_ff[1];
            sdaPrev_ff <= sdaSync_ff[1];
        end
    end

    assign sclNow = sclSync_ff[1];
    assign sdaNow = sdaSync_ff[1];
    assign startSeen = sclNow && sclPrev_ff && sdaPrev_ff && !sdaNow;
    assign stopSeen = sclNow && sclPrev_ff && !sdaPrev_ff && sdaNow;
    assign ctrlWr = sfrReq.wrEn && sfrHit(sfrReq, CTRL_ADDR);
    assign holdDone = holdCnt_ff == 16'h0000;

    smbtc_free_timer u_free_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(ctrl_ff[BIT_FREE_TE] && ctrl_ff[BIT_ENABLE]), // RQ2
        .reloadValue(rate_ff),
        .sclHigh(sclNow),
        .sdaHigh(sdaNow),
        .overflow(freeOvf)
    );

    // Busy follows bus conditions; idle timeout also frees it
    always_ff @(posedge sys_clk)
    begin
        if (srst || !ctrl_ff[BIT_ENABLE])
        begin
            busy_ff <= 1'b0; // RQ10
        end
        else if (startSeen)
        begin
            busy_ff <= 1'b1; // RQ9
        end
        else if (stopSeen || freeOvf)
        begin
            busy_ff <= 1'b0; // RQ9
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            freeTo_ff <= 1'b0;
        end
        else
        begin
            freeTo_ff <= freeOvf; // RQ4
        end
    end

    // Master framing of START, repeated START and STOP
    always_ff @(posedge sys_clk)
    begin
        if (srst || !ctrl_ff[BIT_ENABLE])
        begin
            state_ff <= ST_IDLE; // RQ10
            holdCnt_ff <= 16'h0000;
        end
        else
        begin
            if (!holdDone)
            begin
                holdCnt_ff <= holdCnt_ff - 16'h0001;
            end
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (ctrl_ff[BIT_START])
                    begin
                        // Never jump in on a bus another master holds
                        state_ff <= ST_WAIT_FREE; // RQ11
                    end
                end
                ST_WAIT_FREE:
                begin
                    if (!busy_ff && (freeOvf || !ctrl_ff[BIT_FREE_TE] || stopSeen))
                    begin
                        state_ff <= ST_START_HOLD; // RQ4
                        holdCnt_ff <= 16'(COND_HOLD_CYC);
                    end
                end
                ST_START_HOLD:
                begin
                    if (holdDone)
                    begin
                        state_ff <= ST_MASTER;
                    end
                end
                ST_MASTER:
                begin
                    if (ctrl_ff[BIT_STOP])
                    begin
                        state_ff <= ST_STOP_SETUP;
                        holdCnt_ff <= 16'(COND_HOLD_CYC);
                    end
                    else if (ctrl_ff[BIT_START])
                    begin
                        state_ff <= ST_RS_RELEASE; // RQ11
                        holdCnt_ff <= 16'(COND_HOLD_CYC);
                    end
                end
                ST_RS_RELEASE:
                begin
                    if (holdDone && sclNow)
                    begin
                        state_ff <= ST_START_HOLD; // RQ11
                        holdCnt_ff <= 16'(COND_HOLD_CYC);
                    end
                end
                ST_STOP_SETUP:
                begin
                    if (holdDone && sclNow)
                    begin
                        state_ff <= ST_STOP_HOLD;
                        holdCnt_ff <= 16'(COND_HOLD_CYC);
                    end
                end
                ST_STOP_HOLD:
                begin
                    if (holdDone)
                    begin
                        // Both flags set: START follows the STOP
                        state_ff <= ctrl_ff[BIT_START] ? ST_WAIT_FREE : ST_IDLE; // RQ11
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign genEvent = (state_ff == ST_START_HOLD && holdDone)
        || (state_ff == ST_STOP_HOLD && holdDone);

    // Open-drain drive: SDA low for START hold and STOP setup, SCL low between
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sclOe_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end
        else
        begin
            sdaOe_ff <= (state_ff == ST_START_HOLD) || (state_ff == ST_MASTER)
                || (state_ff == ST_STOP_SETUP);
            sclOe_ff <= (state_ff == ST_MASTER)
                || ((state_ff == ST_STOP_SETUP) && !holdDone);
        end
    end

    // Control register; hardware event set wins over software clear
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl_ff <= CTRL_RESET;
            rate_ff <= RATE_RESET;
        end
        else
        begin
            if (sfrReq.wrEn && sfrHit(sfrReq, RATE_ADDR))
            begin
                rate_ff <= sfrReq.wrData; // RQ5
            end
            if (ctrlWr)
            begin
                ctrl_ff <= sfrReq.wrData; // RQ2
            end
            ctrl_ff[BIT_BUSY] <= 1'b0; // RQ9
            if (genEvent)
            begin
                ctrl_ff[BIT_IRQ] <= 1'b1;
            end
            if (state_ff == ST_START_HOLD && holdDone && !(ctrlWr && sfrReq.wrData[BIT_START]))
            begin
                ctrl_ff[BIT_START] <= 1'b0;
            end
            // A fresh software set in the same cycle survives the hardware clear
            if (((state_ff == ST_STOP_HOLD && holdDone) || (stopSeen && state_ff == ST_IDLE))
                && !(ctrlWr && sfrReq.wrData[BIT_STOP]))
            begin
                ctrl_ff[BIT_STOP] <= 1'b0;
            end
        end
    end

    // Low timeout coupling to the external general timer
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            reload_ff <= 1'b0;
            count_ff <= 1'b0;
        end
        else
        begin
            reload_ff <= ctrl_ff[BIT_LOW_TE] && lowTimerEnabled && sclNow; // RQ7
            count_ff <= ctrl_ff[BIT_LOW_TE] && lowTimerEnabled && !sclNow; // RQ6
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdData_ff <= 8'h00;
        end
        else if (sfrReq.rdEn && sfrHit(sfrReq, CTRL_ADDR))
        begin
            rdData_ff <= {busy_ff, ctrl_ff[BIT_ENABLE:0]}; // RQ9
        end
        else if (sfrReq.rdEn && sfrHit(sfrReq, RATE_ADDR))
        begin
            rdData_ff <= rate_ff;
        end
        else
        begin
            rdData_ff <= 8'h00;
        end
    end

    assign sfrRdData = rdData_ff;
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = sclOe_ff;
    assign sdaOe = sdaOe_ff;
    assign lowTimerReload = reload_ff;
    assign lowTimerCount = count_ff;
    assign busFreeTimeout = freeTo_ff;
endmodule

// [smbtc_top_monitor.sv]
// Purpose: port checker for the bus timeout and control block
// Assumes: sees only the top module ports
// Notes: five-cycle windows cover the line synchroniser lag
`timescale 1ns/1ps
module smbtc_top_monitor
    import smbtc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire smbtc_sfr_req_t sfrReq,
    input wire logic [7:0] sfrRdData,
    // Bus lines
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Timer coupling and status
    input wire logic lowTimerEnabled,
    input wire logic lowTimerReload,
    input wire logic lowTimerCount,
    input wire logic busFreeTimeout
);
    logic [7:0] sdaLowCnt_ff;
    logic enMirror_ff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Saturates so a long hold never wraps back under the limit
    always_ff @(posedge sys_clk)
    begin
        if (srst || !sdaOe)
            sdaLowCnt_ff <= 8'h00;
        else if (sdaLowCnt_ff != 8'hFF)
            sdaLowCnt_ff <= sdaLowCnt_ff + 8'h01;
    end
    sequence s_sclLow; (!sclIn)[*5]; endsequence
    sequence s_sclHigh; sclIn[*5]; endsequence
    // Enable bit as last written on the register port
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            enMirror_ff <= 1'b0;
        else if (sfrReq.wrEn && sfrReq.addr == CTRL_ADDR)
            enMirror_ff <= sfrReq.wrData[BIT_ENABLE];
    end
    sequence s_offLong; (!enMirror_ff)[*3]; endsequence
    sequence s_tmrOff; (!lowTimerEnabled)[*3]; endsequence
    property p_reset_clear;
        $fell(srst) |-> !sclOe && !sdaOe && !busFreeTimeout && sfrRdData == 8'h00;
    endproperty
    property p_rd_idle;
        (!$past(sfrReq.rdEn) || ($past(sfrReq.addr) != CTRL_ADDR
            && $past(sfrReq.addr) != RATE_ADDR)) |-> sfrRdData == 8'h00;
    endproperty
    property p_low_excl; !(lowTimerReload && lowTimerCount); endproperty
    property p_reload_low; s_sclLow |-> !lowTimerReload; endproperty
    property p_count_high; s_sclHigh |-> !lowTimerCount; endproperty
    property p_tmr_off; s_tmrOff |-> !lowTimerReload && !lowTimerCount; endproperty
    property p_free_low; s_sclLow |-> !busFreeTimeout; endproperty
    property p_start_hold; $rose(sclOe) |-> sdaOe && sdaLowCnt_ff >= COND_HOLD_CYC - 2; endproperty
    property p_scl_hold; $rose(sclOe) |=> sclOe[*8]; endproperty
    property p_drv_zero; !sclOut && !sdaOut; endproperty
    property p_off_idle; s_offLong |-> !sclOe && !sdaOe && !busFreeTimeout; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not idle after reset");
    a_rd_idle: assert property (p_rd_idle) else $error("read data without a valid read");
    a_low_excl: assert property (p_low_excl) else $error("reload and count together");
    a_reload_low: assert property (p_reload_low) else $error("reload with clock low");
    a_count_high: assert property (p_count_high) else $error("count with clock high");
    a_tmr_off: assert property (p_tmr_off) else $error("coupling with timer off");
    a_free_low: assert property (p_free_low) else $error("free timeout with clock low");
    a_start_hold: assert property (p_start_hold) else $error("clock pulled before hold");
    a_scl_hold: assert property (p_scl_hold) else $error("clock hold too short");
    a_drv_zero: assert property (p_drv_zero) else $error("line drive value not low");
    a_off_idle: assert property (p_off_idle) else $error("activity while disabled");
endmodule
bind smbtc_top smbtc_top_monitor mon_u (.sys_clk(sys_clk), .srst(srst), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .lowTimerEnabled(lowTimerEnabled),
    .lowTimerReload(lowTimerReload), .lowTimerCount(lowTimerCount),
    .busFreeTimeout(busFreeTimeout));

// [tb_smbus_timeout_and_control.sv]
// Purpose: self-checking bench for the bus timeout and control block
// Assumes: peer model resolves the open-drain lines
// Notes: register port driven at the falling edge
`timescale 1ns/1ps
module tb_smbus_timeout_and_control import smbtc_pkg::*;;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    smbtc_sfr_req_t sfrReq = '0;
    logic lowTimerEnabled = 1'b0;
    logic [7:0] sfrRdData;
    logic sclLine, sdaLine, sclOut, sclOe, sdaOut, sdaOe;
    logic lowTimerReload, lowTimerCount, busFreeTimeout;
    int numErrors = 0;
    int checksDone = 0;
    int cyc = 0;
    smbtc_top dut_u (.sys_clk(sys_clk), .srst(srst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .lowTimerEnabled(lowTimerEnabled), .lowTimerReload(lowTimerReload),
        .lowTimerCount(lowTimerCount), .busFreeTimeout(busFreeTimeout));
    smbtc_bus_peer peer_u (.sclOe(sclOe), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic giveVerdict();
        $display("Counts: %0d checks, %0d errors", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            numErrors++;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        idle(1);
        sfrReq = {2'b10, a, d};
        idle(1);
        sfrReq = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        idle(1);
        sfrReq = {2'b01, a, 8'h00};
        idle(1);
        sfrReq = '0;
        chk(sfrRdData, exp);
    endtask
    // Hang guard, the whole run needs well under this
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            numErrors++;
            giveVerdict();
        end
    end
    initial
    begin
        int i;
        int gap;
        idle(3);
        srst = 1'b0;
        rd(CTRL_ADDR, CTRL_RESET);
        rd(RATE_ADDR, RATE_RESET);
        wr(CTRL_ADDR, 8'h87);
        rd(CTRL_ADDR, 8'h07);
        wr(8'h55, 8'hAA);
        rd(8'h55, 8'h00);
        wr(RATE_ADDR, 8'hF0);
        rd(RATE_ADDR, 8'hF0);
        $display("Test registers done");
        wr(CTRL_ADDR, 8'h42);
        for (i = 0; i < 400 && busFreeTimeout !== 1'b1; i++)
            idle(1);
        idle(1);
        for (gap = 1; gap < 400 && busFreeTimeout !== 1'b1; gap++)
            idle(1);
        chk(8'(gap), 8'h10);
        wr(CTRL_ADDR, 8'h40);
        idle(4);
        gap = 0;
        for (i = 0; i < 300; i++)
        begin
            idle(1);
            gap += busFreeTimeout;
        end
        chk(8'(gap), 8'h00);
        $display("Test free timer done");
        wr(CTRL_ADDR, 8'h62);
        gap = 0;
        for (i = 0; i < 600 && sdaOe !== 1'b1; i++)
        begin
            idle(1);
            gap += busFreeTimeout;
        end
        chk(8'(gap > 0), 8'h01);
        for (i = 0; i < 400 && sclOe !== 1'b1; i++)
            idle(1);
        idle(4);
        rd(CTRL_ADDR, 8'hCA);
        wr(CTRL_ADDR, 8'h52);
        for (i = 0; i < 1000 && sdaOe !== 1'b0; i++)
            idle(1);
        idle(8);
        chk({6'h00, sclOe, sdaOe}, 8'h00);
        // Flag update lands only when the STOP hold has run out
        idle(int'(COND_HOLD_CYC));
        rd(CTRL_ADDR, 8'h4A);
        $display("Test master frame done");
        wr(CTRL_ADDR, 8'h40);
        peer_u.start();
        peer_u.pulses(3);
        rd(CTRL_ADDR, 8'hC0);
        wr(CTRL_ADDR, 8'h60);
        peer_u.pulses(2);
        chk({7'h00, sdaOe}, 8'h00);
        peer_u.stop();
        for (i = 0; i < 600 && sdaOe !== 1'b1; i++)
            idle(1);
        chk({7'h00, sdaOe}, 8'h01);
        for (i = 0; i < 400 && sclOe !== 1'b1; i++)
            idle(1);
        idle(8);
        wr(CTRL_ADDR, 8'h60);
        for (i = 0; i < 400 && sdaOe !== 1'b0; i++)
            idle(1);
        chk({6'h00, sclOe, sdaOe}, 8'h00);
        for (i = 0; i < 600 && sdaOe !== 1'b1; i++)
            idle(1);
        chk({6'h00, sclOe, sdaOe}, 8'h01);
        for (i = 0; i < 400 && sclOe !== 1'b1; i++)
            idle(1);
        wr(CTRL_ADDR, 8'h50);
        for (i = 0; i < 1000 && sdaOe !== 1'b0; i++)
            idle(1);
        wr(CTRL_ADDR, 8'h00);
        peer_u.start();
        rd(CTRL_ADDR, 8'h00);
        peer_u.stop();
        $display("Test shared bus done");
        lowTimerEnabled = 1'b1;
        wr(CTRL_ADDR, 8'h01);
        idle(6);
        chk({6'h00, lowTimerReload, lowTimerCount}, 8'h02);
        peer_u.holdScl(1'b1);
        idle(6);
        chk({6'h00, lowTimerReload, lowTimerCount}, 8'h01);
        lowTimerEnabled = 1'b0;
        idle(6);
        chk({6'h00, lowTimerReload, lowTimerCount}, 8'h00);
        lowTimerEnabled = 1'b1;
        wr(CTRL_ADDR, 8'h00);
        idle(6);
        chk({6'h00, lowTimerReload, lowTimerCount}, 8'h00);
        peer_u.holdScl(1'b0);
        $display("Test low timeout done");
        giveVerdict();
    end
endmodule
